// *** logic/sfb_arbiter.sv ***
// Chosen here: strobed register access.
`timescale 1ns/10ps
// What this block does
// - start register maps onto address bits 26:19
// - start register resets to 0Eh
// - latency timer bounds request to break delay
// - read latency field bits 5:3, four-clock steps
// - PCI read breaks on buffers full or timeout
// - write latency field bits 2:0, resets 011
// - write latency governs only single writes
// - single write breaks: timeout, empty, burst arrives
// - enabled buffer range is not L2 cacheable
// - enable plus redirect makes range DRAM buffer
// - enable without redirect forwards range to PCI
// - half-megabyte start, end at top or hole
// - disabled pins act as fourth PCI pair
module sfb_arbiter
    import sfb_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // memory map and cycle address bits 26:19
    input  wire logic [7:0]  top_of_mem_i,
    input  wire logic [1:0]  hole_sel_i,
    input  wire logic [7:0]  cyc_addr_i,
    output logic             l2_uncacheable_o,
    output logic             route_pci_o,
    output logic             dram_buffer_hit_o,
    // shared request and grant pins
    input  wire logic        gfx_mem_request_n_i,
    output logic             gfx_mem_grant_n_o,
    // fourth pci pair to pci arbiter
    output logic             fourth_pci_request_n_o,
    input  wire logic        fourth_pci_grant_n_i,
    // dram cycle status
    input  wire logic        pci_read_i,
    input  wire logic        single_write_i,
    input  wire logic        burst_write_i,
    input  wire logic        d2p_full_i,
    input  wire logic        dram_write_buffers_empty_i,
    input  wire logic        dram_idle_i,
    output logic             dram_break_o,
    output logic             gfx_owns_dram_o
);

    // ****************************************
    // declarations
    // ****************************************
    logic [1:0]          ctrl;
    logic [7:0]          shared_buffer_start;
    logic [5:0]          gfx_latency_timer_reg;
    logic                shared_buffer_enable;
    logic                shared_buffer_redirect;
    logic                req_meta;
    logic                req_sync;
    logic                gfx_req;
    logic [7:0]          buf_end;
    logic                range_valid;
    logic                in_range;
    logic                read_break;
    logic                write_break;
    logic                wr_ctrl;
    logic                wr_start;
    logic                wr_lat;
    logic                next_grant;
    sfb_state_type       state;
    sfb_state_type       next_state;
    sfb_timer_if         tmr_if ();

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [SFB_CNT_W-1:0] lat_limit(
        input logic [SFB_LAT_FLD_W-1:0] code
    );
        logic [9:0] prod;
        prod = {7'h00, code} * {5'h00, SFB_LAT_STEP_CLKS};
        lat_limit = prod[SFB_CNT_W-1:0];
    endfunction : lat_limit

    function automatic logic [7:0] range_end(
        input logic [7:0] tom,
        input logic [1:0] hole
    );
        range_end = tom;
        if (tom == SFB_TOM_16MB) begin
            case (hole)
                SFB_HOLE_15MB: range_end = SFB_HOLE15_START;
                SFB_HOLE_14MB: range_end = SFB_HOLE14_START;
                default:       range_end = tom;
            endcase
        end
    endfunction : range_end

    function automatic logic addr_in(
        input logic [7:0] addr,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        addr_in = (addr >= lo) && (addr < hi);
    endfunction : addr_in

    function automatic logic reg_hit(
        input logic       strobe,
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        reg_hit = strobe && (addr == ofs);
    endfunction : reg_hit

    // ****************************************
    // register write decode
    // ****************************************
    assign wr_ctrl  = reg_hit(reg_wr_i, reg_addr_i, SFB_OFS_CTRL);
    assign wr_start = reg_hit(reg_wr_i, reg_addr_i, SFB_OFS_START);
    assign wr_lat   = reg_hit(reg_wr_i, reg_addr_i, SFB_OFS_LAT);

    // ****************************************
    // control register
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ctrl <= SFB_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl <= reg_wdata_i[1:0];
        end
    end

    assign shared_buffer_enable   = ctrl[SFB_CTRL_EN_BIT];
    assign shared_buffer_redirect = ctrl[SFB_CTRL_REDIR_BIT];

    // ****************************************
    // start address register
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            shared_buffer_start <= SFB_RST_START;
        end else if (wr_start) begin
            shared_buffer_start <= reg_wdata_i;
        end
    end

    // ****************************************
    // latency timer register
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            gfx_latency_timer_reg <= SFB_RST_LAT;
        end else if (wr_lat) begin
            gfx_latency_timer_reg <= reg_wdata_i[5:0];
        end
    end

    // ****************************************
    // read data, one cycle after strobe
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                SFB_OFS_CTRL:  reg_rdata_o <= {6'h00, ctrl};
                SFB_OFS_START: reg_rdata_o <= shared_buffer_start;
                SFB_OFS_LAT:   reg_rdata_o <= {2'h0, gfx_latency_timer_reg};
                default:       reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ****************************************
    // buffer range decode
    // ****************************************
    assign buf_end     = range_end(top_of_mem_i, hole_sel_i);
    assign range_valid = shared_buffer_start < buf_end;
    assign in_range    = shared_buffer_enable && range_valid
                         && addr_in(cyc_addr_i, shared_buffer_start, buf_end);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            l2_uncacheable_o <= 1'b0;
        end else begin
            l2_uncacheable_o <= in_range;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            route_pci_o <= 1'b0;
        end else begin
            route_pci_o <= in_range && !shared_buffer_redirect;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            dram_buffer_hit_o <= 1'b0;
        end else begin
            dram_buffer_hit_o <= in_range && shared_buffer_redirect;
        end
    end

    // ****************************************
    // request pin synchroniser
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            req_meta <= 1'b1;
            req_sync <= 1'b1;
        end else begin
            req_meta <= gfx_mem_request_n_i;
            req_sync <= req_meta;
        end
    end

    assign gfx_req = shared_buffer_enable && !req_sync;

    // ****************************************
    // break conditions
    // ****************************************
    assign read_break  = pci_read_i && (d2p_full_i || tmr_if.expired);
    assign write_break = single_write_i
                         && (tmr_if.expired || dram_write_buffers_empty_i
                             || burst_write_i);

    // ****************************************
    // latency timer
    // ****************************************
    assign tmr_if.run   = (state == SFB_ST_WAIT);
    assign tmr_if.clear = (state != SFB_ST_WAIT) || !gfx_req;
    assign tmr_if.limit = pci_read_i
        ? lat_limit(gfx_latency_timer_reg[SFB_LAT_RD_LSB +: SFB_LAT_FLD_W])
        : lat_limit(gfx_latency_timer_reg[SFB_LAT_WR_LSB +: SFB_LAT_FLD_W]);

    sfb_latency_timer u_timer (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .tmr     (tmr_if.tmr)
    );

    // ****************************************
    // arbitration state machine
    // ****************************************
    always_comb begin
        next_state = state;
        case (state)
            SFB_ST_IDLE: begin
                if (gfx_req) begin
                    if (pci_read_i || single_write_i) begin
                        next_state = SFB_ST_WAIT;
                    end else if (dram_idle_i) begin
                        next_state = SFB_ST_GRANT;
                    end
                end
            end
            SFB_ST_WAIT: begin
                if (!gfx_req) begin
                    next_state = SFB_ST_IDLE;
                end else if (read_break || write_break) begin
                    next_state = SFB_ST_BREAK;
                end else if (!pci_read_i && !single_write_i) begin
                    // burst writes are not timed
                    next_state = SFB_ST_BREAK;
                end
            end
            SFB_ST_BREAK: begin
                if (!gfx_req) begin
                    next_state = SFB_ST_IDLE;
                end else if (dram_idle_i) begin
                    next_state = SFB_ST_GRANT;
                end
            end
            SFB_ST_GRANT: begin
                if (!gfx_req) begin
                    next_state = SFB_ST_IDLE;
                end
            end
            default: begin
                next_state = SFB_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state <= SFB_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // grant decode
    // ****************************************
    assign next_grant = (next_state == SFB_ST_GRANT);

    // ****************************************
    // dram ownership outputs
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            dram_break_o <= 1'b0;
        end else begin
            dram_break_o <= (next_state == SFB_ST_BREAK);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            gfx_owns_dram_o <= 1'b0;
        end else begin
            gfx_owns_dram_o <= next_grant;
        end
    end

    // ****************************************
    // shared pin function select
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            gfx_mem_grant_n_o <= 1'b1;
        end else if (shared_buffer_enable) begin
            gfx_mem_grant_n_o <= !next_grant;
        end else begin
            gfx_mem_grant_n_o <= fourth_pci_grant_n_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fourth_pci_request_n_o <= 1'b1;
        end else if (shared_buffer_enable) begin
            fourth_pci_request_n_o <= 1'b1;
        end else begin
            fourth_pci_request_n_o <= req_sync;
        end
    end

endmodule : sfb_arbiter

// *** logic/sfb_pkg.sv ***
package sfb_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] SFB_OFS_CTRL  = 8'h73;
    localparam logic [7:0] SFB_OFS_START = 8'h74;
    localparam logic [7:0] SFB_OFS_LAT   = 8'h78;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [1:0] SFB_RST_CTRL  = 2'h0;
    localparam logic [7:0] SFB_RST_START = 8'h0E;
    localparam logic [5:0] SFB_RST_LAT   = 6'h23;

    // ****************************************
    // field positions
    // ****************************************
    localparam int SFB_CTRL_EN_BIT    = 1;
    localparam int SFB_CTRL_REDIR_BIT = 0;
    localparam int SFB_LAT_RD_LSB     = 3;
    localparam int SFB_LAT_WR_LSB     = 0;
    localparam int SFB_LAT_FLD_W      = 3;
    localparam int SFB_CNT_W          = 5;

    // ****************************************
    // timing and memory map constants
    // ****************************************
    localparam logic [4:0] SFB_LAT_STEP_CLKS = 5'h04;
    localparam logic [7:0] SFB_TOM_16MB      = 8'h20;
    localparam logic [7:0] SFB_HOLE15_START  = 8'h1E;
    localparam logic [7:0] SFB_HOLE14_START  = 8'h1C;
    localparam logic [1:0] SFB_HOLE_NONE     = 2'h0;
    localparam logic [1:0] SFB_HOLE_15MB     = 2'h1;
    localparam logic [1:0] SFB_HOLE_14MB     = 2'h2;

    // ****************************************
    // arbitration states
    // ****************************************
    typedef enum logic [1:0] {
        SFB_ST_IDLE,
        SFB_ST_WAIT,
        SFB_ST_BREAK,
        SFB_ST_GRANT
    } sfb_state_type;

endpackage : sfb_pkg

// *** logic/sfb_timer_if.sv ***
`timescale 1ns/10ps
interface sfb_timer_if;
    import sfb_pkg::*;

    logic                     clear;
    logic                     run;
    logic [SFB_CNT_W-1:0]     limit;
    logic                     expired;

    modport ctl (output clear, output run, output limit, input expired);
    modport tmr (input clear, input run, input limit, output expired);

endinterface : sfb_timer_if

// *** logic/sfb_latency_timer.sv ***
`timescale 1ns/10ps
module sfb_latency_timer
    import sfb_pkg::*;
(
    // clock and reset
    input  wire logic  mclk_i,
    input  wire logic  rst_n_i,
    // control from arbiter
    sfb_timer_if.tmr   tmr
);

    logic [SFB_CNT_W-1:0] count;

    // ****************************************
    // host clock counter
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || tmr.clear) begin
            count <= '0;
        end else if (tmr.run && (count < tmr.limit)) begin
            count <= count + 5'h01;
        end
    end

    // limit of zero expires at once
    assign tmr.expired = tmr.run && (count >= tmr.limit);

endmodule : sfb_latency_timer

// *** verif/sfb_arbiter_sva.sv ***
`timescale 1ns/10ps
module sfb_arbiter_sva
    import sfb_pkg::*;
(
    // clock, reset, register port
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_rdata_o,
    // pins and status
    input wire logic       gfx_mem_request_n_i,
    input wire logic       gfx_mem_grant_n_o,
    input wire logic       fourth_pci_request_n_o,
    input wire logic       dram_idle_i,
    input wire logic       dram_break_o,
    input wire logic       gfx_owns_dram_o,
    input wire logic       l2_uncacheable_o,
    input wire logic       route_pci_o,
    input wire logic       dram_buffer_hit_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside slot");
    a_ctrl_reserved: assert property ($past(reg_rd_i) && $past(reg_addr_i) == SFB_OFS_CTRL
        |-> reg_rdata_o[7:2] == 6'h00) else $error("ctrl reserved bits set");
    a_lat_reserved: assert property ($past(reg_rd_i) && $past(reg_addr_i) == SFB_OFS_LAT
        |-> reg_rdata_o[7:6] == 2'h0) else $error("latency reserved bits set");
    a_route_excl: assert property (!(route_pci_o && dram_buffer_hit_o))
        else $error("range routed both ways");
    a_range_nocache: assert property (route_pci_o || dram_buffer_hit_o |-> l2_uncacheable_o)
        else $error("buffer range cacheable");
    a_owner_grant: assert property (gfx_owns_dram_o |-> !gfx_mem_grant_n_o && !dram_break_o)
        else $error("owner without grant");
    a_grant_idle: assert property ($rose(gfx_owns_dram_o) |-> $past(dram_idle_i))
        else $error("grant while dram busy");
    a_grant_req: assert property ($rose(gfx_owns_dram_o) |-> !$past(gfx_mem_request_n_i, 3))
        else $error("grant without request");
    a_grant_drop: assert property ($fell(gfx_owns_dram_o) |-> $past(gfx_mem_request_n_i, 3))
        else $error("grant dropped early");
    a_fourth_req: assert property (!fourth_pci_request_n_o |-> !$past(gfx_mem_request_n_i, 3))
        else $error("fourth request without pin");
    a_break_ends: assert property (dram_break_o && dram_idle_i |=> !dram_break_o)
        else $error("break held with dram idle");
endmodule : sfb_arbiter_sva

bind sfb_arbiter sfb_arbiter_sva chk_u (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_rdata_o(reg_rdata_o), .gfx_mem_request_n_i(gfx_mem_request_n_i),
    .gfx_mem_grant_n_o(gfx_mem_grant_n_o), .fourth_pci_request_n_o(fourth_pci_request_n_o),
    .dram_idle_i(dram_idle_i), .dram_break_o(dram_break_o), .gfx_owns_dram_o(gfx_owns_dram_o),
    .l2_uncacheable_o(l2_uncacheable_o), .route_pci_o(route_pci_o),
    .dram_buffer_hit_o(dram_buffer_hit_o)
);

// *** verif/sfb_gfx_model.sv ***
`timescale 1ns/10ps
module sfb_gfx_model (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // bench control
    input  wire logic       want_i,
    input  wire logic [3:0] hold_i,
    // shared pins
    input  wire logic       gfx_mem_grant_n_i,
    output logic            gfx_mem_request_n_o
);
    logic [1:0] phase;
    logic [3:0] cnt;
    // request held until grant, released after hold_i+1 cycles
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            phase               <= 2'h0;
            cnt                 <= 4'h0;
            gfx_mem_request_n_o <= 1'b1;
        end else begin
            case (phase)
                2'h0: if (want_i) begin
                    gfx_mem_request_n_o <= 1'b0;
                    phase               <= 2'h1;
                end
                2'h1: if (!gfx_mem_grant_n_i) phase <= 2'h2;
                2'h2: begin
                    cnt <= cnt + 4'h1;
                    if (cnt >= hold_i) begin
                        gfx_mem_request_n_o <= 1'b1;
                        cnt                 <= 4'h0;
                        phase               <= 2'h3;
                    end
                end
                default: if (gfx_mem_grant_n_i) phase <= 2'h0;
            endcase
        end
    end
endmodule : sfb_gfx_model

// *** verif/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    import sfb_pkg::*;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic [7:0]  top_of_mem_i = 8'h10;
    logic [1:0]  hole_sel_i = 2'h0;
    logic [7:0]  cyc_addr_i = 8'h00;
    logic        fourth_pci_grant_n_i = 1'b1;
    logic        pci_read_i = 1'b0;
    logic        single_write_i = 1'b0;
    logic        burst_write_i = 1'b0;
    logic        d2p_full_i = 1'b0;
    logic        dram_write_buffers_empty_i = 1'b0;
    logic        dram_idle_i = 1'b0;
    logic        want = 1'b0;
    logic [3:0]  hold = 4'h1;
    logic [7:0]  reg_rdata_o;
    logic        l2_uncacheable_o, route_pci_o, dram_buffer_hit_o, req_n, gfx_mem_grant_n_o;
    logic        fourth_pci_request_n_o, dram_break_o, gfx_owns_dram_o;
    int          failures = 0;
    int          num_checks = 0;
    int          seed = 32'hb6e7;
    int          cyc = 0;
    int          n;
    logic [31:0] s;
    logic [7:0]  v;
    always #20 mclk_i = ~mclk_i;
    sfb_arbiter dut_u (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .top_of_mem_i(top_of_mem_i), .hole_sel_i(hole_sel_i), .cyc_addr_i(cyc_addr_i),
        .l2_uncacheable_o(l2_uncacheable_o), .route_pci_o(route_pci_o),
        .dram_buffer_hit_o(dram_buffer_hit_o), .gfx_mem_request_n_i(req_n),
        .gfx_mem_grant_n_o(gfx_mem_grant_n_o), .fourth_pci_request_n_o(fourth_pci_request_n_o),
        .fourth_pci_grant_n_i(fourth_pci_grant_n_i), .pci_read_i(pci_read_i),
        .single_write_i(single_write_i), .burst_write_i(burst_write_i), .d2p_full_i(d2p_full_i),
        .dram_write_buffers_empty_i(dram_write_buffers_empty_i), .dram_idle_i(dram_idle_i),
        .dram_break_o(dram_break_o), .gfx_owns_dram_o(gfx_owns_dram_o)
    );
    sfb_gfx_model gfx_u (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .want_i(want), .hold_i(hold),
        .gfx_mem_grant_n_i(gfx_mem_grant_n_o), .gfx_mem_request_n_o(req_n)
    );
    // ****************************************
    // tasks
    // ****************************************
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task tick;
        @(posedge mclk_i);
        #1;
    endtask : tick
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr
    task rdc(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge mclk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i   <= 1'b0;
        #1 chk(nm, reg_rdata_o, exp);
    endtask : rdc
    task arb(input logic r, input logic [2:0] ev, input int exp_n);
        @(posedge mclk_i);
        pci_read_i     <= r;
        single_write_i <= !r;
        {d2p_full_i, dram_write_buffers_empty_i, burst_write_i} <= ev;
        hold           <= 4'($random(seed));
        want           <= 1'b1;
        @(posedge mclk_i);
        want <= 1'b0;
        for (n = 1; n < 60; n++) begin
            tick;
            if (dram_break_o === 1'b1) break;
        end
        chk("break delay", 8'(n), 8'(exp_n));
        @(posedge mclk_i);
        dram_idle_i <= 1'b1;
        tick;
        chk("grant", {6'h00, gfx_owns_dram_o, gfx_mem_grant_n_o}, 8'h02);
        {pci_read_i, single_write_i, d2p_full_i, dram_write_buffers_empty_i, burst_write_i} <= 5'h00;
        for (n = 0; n < 40 && gfx_owns_dram_o !== 1'b0; n++) tick;
        chk("release", {7'h00, gfx_owns_dram_o}, 8'h00);
        dram_idle_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask : arb
    function automatic logic [2:0] exp_rng(input logic [7:0] c, st, tom, a, input logic [1:0] h);
        logic [7:0] e;
        logic       hit;
        e = tom;
        if (tom == SFB_TOM_16MB && h == SFB_HOLE_15MB) e = SFB_HOLE15_START;
        if (tom == SFB_TOM_16MB && h == SFB_HOLE_14MB) e = SFB_HOLE14_START;
        hit = c[SFB_CTRL_EN_BIT] && st <= a && a < e;
        return {hit, hit && !c[SFB_CTRL_REDIR_BIT], hit && c[SFB_CTRL_REDIR_BIT]};
    endfunction : exp_rng
    task results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 10000) begin
            failures++;
            results;
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rdc(SFB_OFS_CTRL, 8'h00, "ctrl");
        rdc(SFB_OFS_START, 8'h0E, "start");
        rdc(SFB_OFS_LAT, 8'h23, "lat");
        rdc(8'h70, 8'h00, "unmapped");
        wr(SFB_OFS_CTRL, 8'hFF);
        rdc(SFB_OFS_CTRL, 8'h03, "ctrl");
        s = $random(seed);
        v = s[7:0] | 8'h02;
        wr(SFB_OFS_START, v);
        rdc(SFB_OFS_START, v, "start");
        $display("test registers done");
        arb(1'b1, 3'b000, 20);
        arb(1'b0, 3'b000, 16);
        for (int i = 0; i < 8; i++) begin
            v = {2'b00, 3'(i), 3'(7 - i)};
            wr(SFB_OFS_LAT, v);
            rdc(SFB_OFS_LAT, v, "lat");
            arb(1'b1, 3'b000, 4 + 4 * i);
            arb(1'b0, 3'b000, 4 + 4 * (7 - i));
        end
        wr(SFB_OFS_LAT, 8'h3F);
        arb(1'b1, 3'b100, 4);
        arb(1'b0, 3'b010, 4);
        arb(1'b0, 3'b001, 4);
        @(posedge mclk_i);
        pci_read_i <= 1'b1;
        want       <= 1'b1;
        @(posedge mclk_i);
        want <= 1'b0;
        repeat (6) @(posedge mclk_i);
        pci_read_i    <= 1'b0;
        burst_write_i <= 1'b1;
        tick;
        chk("untimed break", {7'h00, dram_break_o}, 8'h01);
        @(posedge mclk_i);
        burst_write_i <= 1'b0;
        dram_idle_i   <= 1'b1;
        tick;
        chk("untimed grant", {7'h00, gfx_owns_dram_o}, 8'h01);
        for (n = 0; n < 40 && gfx_owns_dram_o !== 1'b0; n++) tick;
        repeat (2) @(posedge mclk_i);
        want <= 1'b1;
        @(posedge mclk_i);
        want <= 1'b0;
        #1;
        for (n = 0; n < 10 && gfx_owns_dram_o !== 1'b1; n++) tick;
        chk("direct grant", 8'(n), 8'h03);
        for (n = 0; n < 40 && gfx_owns_dram_o !== 1'b0; n++) tick;
        chk("direct release", {7'h00, gfx_owns_dram_o}, 8'h00);
        dram_idle_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        $display("test arbitration done");
        for (int i = 0; i < 24; i++) begin
            s = $random(seed);
            if (i < 2) s = 32'h3A8172 + (i << 17);
            v = (s[7:2] < 2) ? 8'h02 : {2'b00, s[7:2]};
            wr(SFB_OFS_CTRL, {6'h00, s[1:0]});
            wr(SFB_OFS_START, v);
            @(posedge mclk_i);
            top_of_mem_i <= s[8] ? SFB_TOM_16MB : {2'b00, s[14:9]};
            hole_sel_i   <= s[16:15];
            cyc_addr_i   <= {2'b00, s[22:17]};
            tick;
            chk("range", {5'h00, l2_uncacheable_o, route_pci_o, dram_buffer_hit_o},
                {5'h00, exp_rng({6'h00, s[1:0]}, v, top_of_mem_i, cyc_addr_i, hole_sel_i)});
        end
        $display("test range done");
        wr(SFB_OFS_CTRL, 8'h00);
        @(posedge mclk_i);
        want <= 1'b1;
        @(posedge mclk_i);
        want <= 1'b0;
        #1;
        for (n = 0; n < 10 && fourth_pci_request_n_o !== 1'b0; n++) tick;
        chk("fourth request", 8'(n), 8'h03);
        @(posedge mclk_i);
        fourth_pci_grant_n_i <= 1'b0;
        tick;
        chk("fourth grant", {7'h00, gfx_mem_grant_n_o}, 8'h00);
        for (n = 0; n < 40 && fourth_pci_request_n_o !== 1'b1; n++) tick;
        fourth_pci_grant_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        $display("test fourth pair done");
        results;
    end
endmodule : testbench
